// ==== adc_conversion_sequencer.sv ====
// Successive-approximation converter sequencer with register port and result pair.
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// - Bit period from six divisions or RC.
// - Nine bit periods per eight-bit portion.
// - Two bit period gap after completion.
// - Abort keeps previous result pair.
// - After abort, wait two periods, reacquire.
// - First segment one cycle to one period.
// - Result justified into sixteen bits, zero fill.
// - Disabled converter leaves result as storage.
// - Analog pins read zero on port.
// - Convert selected channel whatever pin setup.
// - Holding capacitor never actively discharged.
// - Completion clears start, loads, flags together.
// - Format bit picks right or left justify.
module adc_conversion_sequencer
  import adc_seq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic we,
  input wire logic re,
  output logic [DATA_W-1:0] rdata,
  input wire logic rc_clk,
  input wire logic cmp_keep,
  input wire logic [6:0] port_pins,
  output logic [2:0] analog_channel,
  output logic sample_connect,
  output logic [RESULT_W-1:0] sar_trial,
  output logic conv_done_flag,
  output logic converter_enable
);

  typedef struct packed {
    seq_state_e st;
    logic enable;
    logic go;
    logic [1:0] clk_sel;
    logic [2:0] chan;
    logic fmt;
    logic halve;
    logic [7:0] res_hi;
    logic [7:0] res_lo;
    logic [6:0] analog_pin_select;
    logic done_flag;
    logic [3:0] bit_idx;
    logic [RESULT_W-1:0] sar;
    logic [1:0] tad_cnt;
    logic sample_connect;
    logic [DATA_W-1:0] rdata;
  } seq_s;

  seq_s s_reg;
  seq_s s_next;
  logic tad_tick;
  logic busy;
  logic ctl0_wr;
  logic start;
  logic abort;
  logic done_evt;

  function automatic logic [15:0] justify(input logic [RESULT_W-1:0] r, input logic right);
    if (right) begin
      justify = {{PAD_W{1'b0}}, r};
    end else begin
      justify = {r, {PAD_W{1'b0}}};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////

  conv_clock_gen u_clock_gen (
    .clk(clk),
    .rst_n(rst_n),
    .conv_clock_select(s_reg.clk_sel),
    .clock_halve_select(s_reg.halve),
    .rc_clk(rc_clk),
    .tad_tick(tad_tick)
  );

  ////////////////////////////////////////////////////////////////////////////////

  always_comb begin
    s_next = s_reg;
    s_next.rdata = 8'h00;
    busy = (s_reg.st == ST_FIRST) || (s_reg.st == ST_SETTLE) || (s_reg.st == ST_BITS);
    ctl0_wr = we && (addr == ADDR_CONTROL0);
    // Start needs the converter already on, so one write cannot do both.
    start = ctl0_wr && wdata[GO_BIT] && s_reg.enable && (s_reg.st == ST_ACQUIRE);
    abort = ctl0_wr && busy && (!wdata[GO_BIT] || !wdata[ENABLE_BIT]);
    done_evt = 1'b0;

    if (re) begin
      case (addr)
        ADDR_CONTROL0: s_next.rdata = {s_reg.clk_sel, s_reg.chan, s_reg.go, 1'b0, s_reg.enable};
        ADDR_CONTROL1: s_next.rdata = {s_reg.fmt, s_reg.halve, 6'h00};
        ADDR_RESULT_HIGH: s_next.rdata = s_reg.res_hi;
        ADDR_RESULT_LOW: s_next.rdata = s_reg.res_lo;
        ADDR_ANALOG_SEL: s_next.rdata = {1'b0, s_reg.analog_pin_select};
        ADDR_PORT_READ: s_next.rdata = {1'b0, port_pins & ~s_reg.analog_pin_select};
        ADDR_STATUS: s_next.rdata = {7'h00, s_reg.done_flag};
        default: s_next.rdata = 8'h00;
      endcase
    end

    if (ctl0_wr) begin
      s_next.clk_sel = wdata[CLK_SEL_LSB +: 2];
      s_next.chan = wdata[CHAN_LSB +: 3];
      s_next.enable = wdata[ENABLE_BIT];
    end
    if (we && addr == ADDR_CONTROL1) begin
      s_next.fmt = wdata[FORMAT_BIT];
      s_next.halve = wdata[HALVE_BIT];
    end
    // Plain storage writes; a completing conversion below overrides them.
    if (we && addr == ADDR_RESULT_HIGH) begin
      s_next.res_hi = wdata;
    end
    if (we && addr == ADDR_RESULT_LOW) begin
      s_next.res_lo = wdata;
    end
    if (we && addr == ADDR_ANALOG_SEL) begin
      s_next.analog_pin_select = wdata[6:0];
    end
    if (we && addr == ADDR_STATUS && !wdata[DONE_BIT]) begin
      s_next.done_flag = 1'b0;
    end

    case (s_reg.st)
      ST_ACQUIRE: begin
        if (start) begin
          s_next.go = 1'b1;
          s_next.st = ST_FIRST;
        end
      end
      ST_FIRST: begin
        // Leaves on the next bit tick, so it spans one cycle up to one period.
        if (tad_tick) begin
          s_next.st = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        // One overhead period before the decisions, as in nine per eight bits.
        if (tad_tick) begin
          s_next.st = ST_BITS;
          s_next.sar = 10'h200;
          s_next.bit_idx = MSB_INDEX;
        end
      end
      ST_BITS: begin
        if (tad_tick) begin
          s_next.sar[s_reg.bit_idx] = cmp_keep;
          if (s_reg.bit_idx == 4'h0) begin
            done_evt = 1'b1;
            {s_next.res_hi, s_next.res_lo} = justify(s_next.sar, s_reg.fmt);
            s_next.go = 1'b0;
            s_next.done_flag = 1'b1;
            s_next.st = ST_HOLDOFF;
            s_next.tad_cnt = 2'h0;
          end else begin
            s_next.bit_idx = s_reg.bit_idx - 4'h1;
            s_next.sar[s_reg.bit_idx - 4'h1] = 1'b1;
          end
        end
      end
      ST_HOLDOFF: begin
        if (tad_tick) begin
          if (s_reg.tad_cnt == HOLDOFF_LAST) begin
            s_next.st = ST_ACQUIRE;
          end else begin
            s_next.tad_cnt = s_reg.tad_cnt + 2'h1;
          end
        end
      end
      default: s_next.st = ST_ACQUIRE;
    endcase

    // An abort on the last decision tick still discards that result.
    if (abort) begin
      done_evt = 1'b0;
      s_next.res_hi = s_reg.res_hi;
      s_next.res_lo = s_reg.res_lo;
      s_next.done_flag = s_reg.done_flag;
      s_next.go = 1'b0;
      s_next.st = ST_HOLDOFF;
      s_next.tad_cnt = 2'h0;
    end

    // The capacitor is only switched to the channel, never to a discharge path.
    s_next.sample_connect = (s_next.st == ST_ACQUIRE) && s_next.enable;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.st <= ST_ACQUIRE;
      s_reg.analog_pin_select <= ANALOG_SEL_RESET;
      s_reg.res_hi <= RESULT_RESET;
      s_reg.res_lo <= RESULT_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata = s_reg.rdata;
  assign analog_channel = s_reg.chan;
  assign sample_connect = s_reg.sample_connect;
  assign sar_trial = s_reg.sar;
  assign conv_done_flag = s_reg.done_flag;
  assign converter_enable = s_reg.enable;

  ////////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_first_segment: assert property ((s_reg.st == ST_FIRST && tad_tick && !abort)
    |=> s_reg.st == ST_SETTLE)
    else $error("first segment did not end on the bit tick");

  a_start_first: assert property (start |=> s_reg.go && s_reg.st == ST_FIRST)
    else $error("start did not enter the first segment");

  a_holdoff_gap: assert property ($fell(s_reg.go) |-> !s_reg.sample_connect
    ##1 !s_reg.sample_connect)
    else $error("capacitor reconnected during the gap");

  a_done_event: assert property (done_evt |=> s_reg.done_flag && !s_reg.go
    && {s_reg.res_hi, s_reg.res_lo} == justify(s_reg.sar, $past(s_reg.fmt)))
    else $error("completion event incomplete");

  a_right_zero: assert property ((done_evt && s_reg.fmt) |=> s_reg.res_hi[7:2] == 6'h00)
    else $error("right justified high bits not zero");

  a_abort_keep: assert property (abort |=> $stable({s_reg.res_hi, s_reg.res_lo})
    && !s_reg.done_flag == !$past(s_reg.done_flag))
    else $error("abort disturbed the result pair");

  a_abort_reacq: assert property (abort |=> s_reg.st == ST_HOLDOFF && s_reg.tad_cnt == 2'h0)
    else $error("abort did not enter the gap");

  a_port_zero: assert property ((re && addr == ADDR_PORT_READ)
    |=> (s_reg.rdata[6:0] & $past(s_reg.analog_pin_select)) == 7'h00)
    else $error("analog pin read as high");

  a_sar_order: assert property ((s_reg.st == ST_BITS && tad_tick && s_reg.bit_idx != 4'h0
    && !abort) |=> s_reg.bit_idx == $past(s_reg.bit_idx) - 4'h1)
    else $error("decisions not taken msb first");

  a_storage_write: assert property ((we && addr == ADDR_RESULT_HIGH && !busy)
    |=> s_reg.res_hi == $past(wdata))
    else $error("result high not writable");

  c_conversion_done: cover property (done_evt);
  c_abort_seen: cover property (abort);
  c_rc_done: cover property (done_evt && s_reg.clk_sel == CLK_SEL_RC);
  c_left_done: cover property (done_evt && !s_reg.fmt);

endmodule

// ==== adc_seq_pkg.sv ====
// Constants, register map and state encoding shared by the converter sequencer.
package adc_seq_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;
  localparam int RESULT_W = 10;
  localparam int PAD_W = 16 - RESULT_W;

  // Register offsets.
  localparam logic [ADDR_W-1:0] ADDR_CONTROL0 = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL1 = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_RESULT_HIGH = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_RESULT_LOW = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_ANALOG_SEL = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_PORT_READ = 3'h5;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h6;

  // Control register 0 fields.
  localparam int CLK_SEL_LSB = 6;
  localparam int CHAN_LSB = 3;
  localparam int GO_BIT = 2;
  localparam int ENABLE_BIT = 0;
  // Control register 1 fields.
  localparam int FORMAT_BIT = 7;
  localparam int HALVE_BIT = 6;
  // Status register field.
  localparam int DONE_BIT = 0;

  localparam logic [1:0] CLK_SEL_RC = 2'h3;
  localparam logic [6:0] ANALOG_SEL_RESET = 7'h7f;
  localparam logic [7:0] RESULT_RESET = 8'h00;

  // Divider terminal counts: bit period is the count plus one system clocks.
  localparam logic [5:0] DIV2_LAST = 6'h01;
  localparam logic [5:0] DIV4_LAST = 6'h03;
  localparam logic [5:0] DIV8_LAST = 6'h07;
  localparam logic [5:0] DIV16_LAST = 6'h0f;
  localparam logic [5:0] DIV32_LAST = 6'h1f;
  localparam logic [5:0] DIV64_LAST = 6'h3f;

  // Bit periods of the sequence.
  localparam logic [3:0] MSB_INDEX = 4'h9;
  localparam logic [1:0] HOLDOFF_LAST = 2'h1;

  typedef enum logic [2:0] {
    ST_ACQUIRE,
    ST_FIRST,
    ST_SETTLE,
    ST_BITS,
    ST_HOLDOFF
  } seq_state_e;

endpackage

// ==== conv_clock_gen.sv ====
// Conversion bit period tick generator from divided system clock or RC source.
`timescale 1ns/1ps
module conv_clock_gen
  import adc_seq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] conv_clock_select,
  input wire logic clock_halve_select,
  input wire logic rc_clk,
  output logic tad_tick
);

  typedef struct packed {
    logic rc_meta;
    logic rc_sync;
    logic rc_last;
    logic [5:0] cnt;
    logic tick;
  } gen_s;

  gen_s s_reg;
  gen_s s_next;
  logic [5:0] last;

  always_comb begin
    s_next = s_reg;
    case ({conv_clock_select, clock_halve_select})
      3'h0: last = DIV2_LAST;
      3'h1: last = DIV4_LAST;
      3'h2: last = DIV8_LAST;
      3'h3: last = DIV16_LAST;
      3'h4: last = DIV32_LAST;
      3'h5: last = DIV64_LAST;
      default: last = DIV2_LAST;
    endcase
    // The RC source is asynchronous; its first stage feeds only the second.
    s_next.rc_meta = rc_clk;
    s_next.rc_sync = s_reg.rc_meta;
    s_next.rc_last = s_reg.rc_sync;
    s_next.cnt = (s_reg.cnt >= last) ? 6'h00 : s_reg.cnt + 6'h01;
    if (conv_clock_select == CLK_SEL_RC) begin
      s_next.tick = s_reg.rc_sync && !s_reg.rc_last;
    end else begin
      s_next.tick = (s_reg.cnt >= last);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tad_tick = s_reg.tick;

  // The setting must also hold in the cycle after the tick, since that cycle sets the next one.
  a_fastest_period: assert property (@(posedge clk) disable iff (!rst_n)
    (conv_clock_select == 2'h0 && !clock_halve_select && $stable(conv_clock_select)
     && tad_tick) ##1 (conv_clock_select == 2'h0 && !clock_halve_select)
    |-> !tad_tick ##1 tad_tick)
    else $error("divide by two tick period wrong");

endmodule

// ==== adc_far_side_model.sv ====
// Far-side model: comparator on a held channel level and the RC oscillator.
`timescale 1ns/1ps
module adc_far_side_model
  import adc_seq_pkg::*;
#(
  // A 2 us bit period keeps the RC case inside the allowed range.
  parameter int RC_HALF_NS = 1000
)
(
  input wire logic clk,
  input wire logic rc_run,
  input wire logic [2:0] analog_channel,
  input wire logic sample_connect,
  input wire logic [RESULT_W-1:0] sar_trial,
  output logic cmp_keep,
  output logic rc_clk
);
  logic [RESULT_W-1:0] held_reg = '0;
  initial rc_clk = 1'b0;
  // The level is refreshed only while connected and never drained in between.
  always @(posedge clk) begin
    if (sample_connect) begin
      held_reg <= {analog_channel, 7'h2d};
    end
  end
  assign cmp_keep = (sar_trial <= held_reg);
  // The oscillator runs only when asked, so no stray edge leaks into other tests.
  always #(RC_HALF_NS) begin
    if (rc_run) begin
      rc_clk = ~rc_clk;
    end
  end
endmodule

// ==== tb.sv ====
// Self-checking bench for the converter sequencer with its far-side model.
`timescale 1ns/1ps
module tb
  import adc_seq_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic rc_clk;
  logic rc_run = 1'b0;
  logic cmp_keep;
  logic [6:0] port_pins = 7'h7f;
  logic [2:0] analog_channel;
  logic sample_connect;
  logic [RESULT_W-1:0] sar_trial;
  logic conv_done_flag;
  logic converter_enable;
  logic [9:0] last_r;
  logic last_f;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;

  adc_conversion_sequencer u_adc_conversion_sequencer (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .we(we), .re(re), .rdata(rdata), .rc_clk(rc_clk), .cmp_keep(cmp_keep),
    .port_pins(port_pins), .analog_channel(analog_channel), .sample_connect(sample_connect),
    .sar_trial(sar_trial), .conv_done_flag(conv_done_flag),
    .converter_enable(converter_enable));
  adc_far_side_model u_adc_far_side_model (.clk(clk), .rc_run(rc_run),
    .analog_channel(analog_channel), .sample_connect(sample_connect), .sar_trial(sar_trial),
    .cmp_keep(cmp_keep), .rc_clk(rc_clk));

  always #5 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // A hung handshake would otherwise stall the run for ever.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      bad_count++;
      stop_test();
    end
  end

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic span(input int n, input int lo, input int hi);
    checks++;
    if (n < lo || n > hi) begin
      bad_count++;
      $display("mismatch at %0t: %0d cycles not in %0d..%0d", $time, n, lo, hi);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask

  task automatic chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    logic [DATA_W-1:0] d;
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    d = rdata;
    cmp(d, e);
  endtask

  task automatic wait_hi(input bit sel, output int n);
    n = 0;
    while ((sel ? sample_connect : conv_done_flag) !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  task automatic chk_result();
    chk(ADDR_RESULT_HIGH, last_f ? {6'h00, last_r[9:8]} : last_r[9:2]);
    chk(ADDR_RESULT_LOW, last_f ? last_r[7:0] : {last_r[1:0], 6'h00});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic convert(input logic [1:0] cs, input logic hv, input logic fmt,
                         input logic [2:0] ch, input int p);
    int n;
    last_r = {ch, 7'h2d};
    last_f = fmt;
    wr(ADDR_CONTROL1, {fmt, hv, 6'h00});
    wr(ADDR_CONTROL0, {cs, ch, 3'h1});
    repeat (4) @(posedge clk);
    wr(ADDR_CONTROL0, {cs, ch, 3'h5});
    wait_hi(1'b0, n);
    if (p > 0) span(n, 11 * p, 12 * p + 3);
    cmp({7'h00, sample_connect}, 8'h00);
    cmp({5'h00, analog_channel}, {5'h00, ch});
    cmp({7'h00, converter_enable}, 8'h01);
    wait_hi(1'b1, n);
    if (p > 0) span(n, 2 * p - 3, 2 * p + 2);
    chk(ADDR_CONTROL0, {cs, ch, 3'h1});
    chk(ADDR_STATUS, 8'h01);
    wr(ADDR_STATUS, 8'h00);
    chk_result();
  endtask

  // Clock select 01 with halving gives a period of 16 cycles here.
  task automatic abort_run();
    int n;
    wr(ADDR_CONTROL0, 8'h71);
    repeat (4) @(posedge clk);
    wr(ADDR_CONTROL0, 8'h75);
    repeat (40) @(posedge clk);
    wr(ADDR_CONTROL0, 8'h71);
    wait_hi(1'b1, n);
    span(n, 16, 35);
    chk(ADDR_STATUS, 8'h00);
    chk(ADDR_CONTROL0, 8'h71);
    chk_result();
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    chk(ADDR_ANALOG_SEL, 8'h7f);
    chk(ADDR_CONTROL0, 8'h00);
    chk(3'h7, 8'h00);
    wr(ADDR_RESULT_HIGH, 8'ha5);
    wr(ADDR_RESULT_LOW, 8'h5a);
    chk(ADDR_RESULT_HIGH, 8'ha5);
    chk(ADDR_RESULT_LOW, 8'h5a);
    wr(ADDR_ANALOG_SEL, 8'h55);
    chk(ADDR_PORT_READ, 8'h2a);
    @(posedge clk);
    port_pins <= 7'h0f;
    chk(ADDR_PORT_READ, 8'h0a);
    wr(ADDR_CONTROL0, 8'h05);
    chk(ADDR_CONTROL0, 8'h01);
    convert(2'h0, 1'b0, 1'b1, 3'h5, 2);
    convert(2'h1, 1'b1, 1'b0, 3'h3, 16);
    abort_run();
    convert(2'h2, 1'b1, 1'b1, 3'h6, 64);
    convert(2'h0, 1'b1, 1'b0, 3'h1, 4);
    convert(2'h1, 1'b0, 1'b1, 3'h2, 8);
    convert(2'h2, 1'b0, 1'b0, 3'h4, 32);
    // The RC run stands in for a conversion taken while the core sleeps.
    rc_run <= 1'b1;
    convert(2'h3, 1'b0, 1'b1, 3'h0, 200);
    stop_test();
  end
endmodule
